// ### pcv_defines.svh
// Constants for the pump configuration and version tag register slice
//==============================================================
`ifndef PCV_DEFINES_SVH
`define PCV_DEFINES_SVH

//==============================================================
// Register access port widths
`define PCV_ADDR_W          12
`define PCV_DATA_W          8

//==============================================================
// Register offsets
`define PCV_OFS_TAG_LOW     12'h005
`define PCV_OFS_TAG_HIGH    12'h006
`define PCV_OFS_PUMP_CFG    12'h010

//==============================================================
// Reset values, configuration write mask and unmapped read data
`define PCV_RST_TAG_LOW     8'h00
`define PCV_RST_TAG_HIGH    8'h00
`define PCV_RST_PUMP_CFG    8'h7c
`define PCV_PUMP_CFG_WMASK  8'hfc
`define PCV_UNMAPPED_DATA   8'h00

//==============================================================
// Pump configuration field positions
`define PCV_SENSE_BIT       7
`define PCV_CUR_HI          6
`define PCV_CUR_LO          4
`define PCV_MODE_HI         3
`define PCV_MODE_LO         2

//==============================================================
// Pump current scale, one step in microamps
`define PCV_CUR_STEP_UA     13'h0258
`define PCV_CUR_UA_W        13

`endif

// ### pcv_pkg.sv
// Types shared by the pump configuration and version tag slice
package pcv_pkg;

	// Charge pump operating modes, in field encoding order
	typedef enum logic [1:0] {
		PCV_MODE_HIZ,
		PCV_MODE_SOURCE,
		PCV_MODE_SINK,
		PCV_MODE_NORMAL
	} pcv_pump_mode_t;

	// One byte of register data
	typedef logic [7:0] pcv_byte_t;

endpackage : pcv_pkg

// ### pcv_byte_reg.sv
// One software-writable byte register with masked write and reset value
`timescale 1ns/100ps
`include "pcv_defines.svh"

module pcv_byte_reg
	import pcv_pkg::*;
#(
	parameter pcv_byte_t RESET_VAL = 8'h00,	// Value after reset
	parameter pcv_byte_t WR_MASK   = 8'hff	// Bits that a write may change
)
(
	input  wire logic      clk_sys,	// System clock
	input  wire logic      rst,		// Asynchronous reset, active high
	input  wire logic      wr_en,	// Write strobe for this register
	input  wire pcv_byte_t wdata,	// Write data
	output pcv_byte_t      q_nxt,	// Value the register takes next edge
	output pcv_byte_t      q		// Current stored value
);

	//==============================================================
	// Next value: merge written bits, keep the rest
	always_comb
	begin
		q_nxt = q;
		if (wr_en)
		begin
			q_nxt = (wdata & WR_MASK) | (q & ~WR_MASK);
		end
	end

	//==============================================================
	// Storage
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			q <= RESET_VAL;
		end
		else
		begin
			q <= q_nxt;
		end
	end

endmodule : pcv_byte_reg

// ### pcv_pump_cfg_regs.sv
// Pump detector configuration and stored settings version tag registers
`timescale 1ns/100ps
`include "pcv_defines.svh"

module pcv_pump_cfg_regs
	import pcv_pkg::*;
#(
	parameter int NUM_REGS = 3	// Registers in this slice
)
(
	input  wire logic                      clk_sys,		// System clock, 40 MHz
	input  wire logic                      rst,			// Async reset, active high
	input  wire logic [`PCV_ADDR_W-1:0]    reg_addr,		// Register address
	input  wire pcv_byte_t                 reg_wdata,		// Write data
	input  wire logic                      reg_wr,		// Write strobe, one cycle
	input  wire logic                      reg_rd,		// Read strobe, one cycle
	input  wire logic                      osc_internal,	// On-chip oscillator selected
	output pcv_byte_t                      reg_rdata,		// Read data
	output logic                           reg_rvalid,	// Read data valid pulse
	output logic                           reg_hit,		// Last read hit a register
	output logic [15:0]                    stored_settings_version_tag, // Version tag
	output logic                           detector_sense_select, // 1 = negative sense
	output logic [2:0]                     pump_current_select,	// Current code
	output logic [`PCV_CUR_UA_W-1:0]       pump_current_ua,	// Current in microamps
	output pcv_pump_mode_t                 pump_operating_mode,	// Pump mode
	output logic                           pump_source_en,	// Pump forced up
	output logic                           pump_sink_en,		// Pump forced down
	output logic                           pump_hiz,		// Pump output off
	output logic                           pump_normal,		// Pump driven by detector
	output logic                           sense_misuse		// Negative sense on chip osc
);

	//==============================================================
	// Register table
	localparam logic [`PCV_ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
		`PCV_OFS_TAG_LOW,
		`PCV_OFS_TAG_HIGH,
		`PCV_OFS_PUMP_CFG
	};
	localparam pcv_byte_t REG_RST [NUM_REGS] = '{
		`PCV_RST_TAG_LOW,
		`PCV_RST_TAG_HIGH,
		`PCV_RST_PUMP_CFG
	};
	localparam pcv_byte_t REG_WMASK [NUM_REGS] = '{
		8'hff,
		8'hff,
		`PCV_PUMP_CFG_WMASK
	};
	localparam int IDX_TAG_LOW  = 0;
	localparam int IDX_TAG_HIGH = 1;
	localparam int IDX_PUMP_CFG = 2;

	//==============================================================
	// Address decode, shared by write and read paths
	function automatic logic [NUM_REGS-1:0] decode_addr(
		input logic [`PCV_ADDR_W-1:0] addr
	);
		logic [NUM_REGS-1:0] sel;
		sel = '0;
		for (int i = 0; i < NUM_REGS; i++)
		begin
			sel[i] = (addr == REG_OFS[i]);
		end
		return sel;
	endfunction : decode_addr

	// Pump current in microamps for a current code
	function automatic logic [`PCV_CUR_UA_W-1:0] code_to_ua(
		input logic [2:0] code
	);
		logic [`PCV_CUR_UA_W-1:0] steps;
		steps = {{(`PCV_CUR_UA_W-3){1'b0}}, code} + `PCV_CUR_UA_W'(1);
		return `PCV_CUR_UA_W'(steps * `PCV_CUR_STEP_UA);
	endfunction : code_to_ua

	//==============================================================
	// Register storage
	logic      [NUM_REGS-1:0] wr_sel;
	pcv_byte_t                reg_q   [NUM_REGS];
	pcv_byte_t                reg_n   [NUM_REGS];

	// Each register is written only when its own offset matches
	assign wr_sel = reg_wr ? decode_addr(reg_addr) : '0;

	generate
		for (genvar g = 0; g < NUM_REGS; g++)
		begin : g_reg
			pcv_byte_reg #(
				.RESET_VAL (REG_RST[g]),
				.WR_MASK   (REG_WMASK[g])
			) u_reg (
				.clk_sys (clk_sys),
				.rst     (rst),
				.wr_en   (wr_sel[g]),
				.wdata   (reg_wdata),
				.q_nxt   (reg_n[g]),
				.q       (reg_q[g])
			);
		end
	endgenerate

	//==============================================================
	// Version tag output, storage only, drives no other function
	assign stored_settings_version_tag = {reg_q[IDX_TAG_HIGH], reg_q[IDX_TAG_LOW]};

	//==============================================================
	// Read path state
	pcv_byte_t rdata_r;
	pcv_byte_t rdata_nxt;
	logic      rvalid_r;
	logic      rvalid_nxt;
	logic      hit_r;
	logic      hit_nxt;

	// Select stored value for a read; unmapped offsets return zero
	always_comb
	begin
		logic [NUM_REGS-1:0] rd_sel;
		rd_sel     = decode_addr(reg_addr);
		rdata_nxt  = rdata_r;
		rvalid_nxt = reg_rd;
		hit_nxt    = hit_r;
		if (reg_rd)
		begin
			rdata_nxt = `PCV_UNMAPPED_DATA;
			hit_nxt   = |rd_sel;
			for (int i = 0; i < NUM_REGS; i++)
			begin
				if (rd_sel[i])
				begin
					rdata_nxt = reg_q[i];
				end
			end
		end
	end

	// Read path registers
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
			hit_r    <= 1'b0;
		end
		else
		begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			hit_r    <= hit_nxt;
		end
	end

	assign reg_rdata  = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign reg_hit    = hit_r;

	//==============================================================
	// Pump control reset fields, taken from the configuration reset value
	localparam pcv_byte_t CFG_RST = `PCV_RST_PUMP_CFG;
	localparam logic [`PCV_CUR_UA_W-1:0] UA_RST = code_to_ua(CFG_RST[`PCV_CUR_HI:`PCV_CUR_LO]);

	// Pump control state, decoded from the configuration next value
	logic           sense_r;
	logic           sense_nxt;
	logic [2:0]     cur_r;
	logic [2:0]     cur_nxt;
	logic [`PCV_CUR_UA_W-1:0] ua_r;
	logic [`PCV_CUR_UA_W-1:0] ua_nxt;
	pcv_pump_mode_t mode_r;
	pcv_pump_mode_t mode_nxt;
	logic [3:0]     drive_r;	// {normal, hiz, sink, source}
	logic [3:0]     drive_nxt;
	logic           misuse_r;
	logic           misuse_nxt;

	// Field extraction and mode decode
	always_comb
	begin
		pcv_byte_t cfg;
		cfg        = reg_n[IDX_PUMP_CFG];
		sense_nxt  = cfg[`PCV_SENSE_BIT];
		cur_nxt    = cfg[`PCV_CUR_HI:`PCV_CUR_LO];
		ua_nxt     = code_to_ua(cur_nxt);
		mode_nxt   = pcv_pump_mode_t'(cfg[`PCV_MODE_HI:`PCV_MODE_LO]);
		drive_nxt  = 4'h0;
		unique case (mode_nxt)
			PCV_MODE_HIZ:    drive_nxt = 4'h4;
			PCV_MODE_SOURCE: drive_nxt = 4'h1;
			PCV_MODE_SINK:   drive_nxt = 4'h2;
			PCV_MODE_NORMAL: drive_nxt = 4'h8;
		endcase
		// Flags software breaking the sense restriction on the chip oscillator
		misuse_nxt = sense_nxt & osc_internal;
	end

	// Pump control registers, reset to the configuration reset fields
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sense_r  <= CFG_RST[`PCV_SENSE_BIT];
			cur_r    <= CFG_RST[`PCV_CUR_HI:`PCV_CUR_LO];
			ua_r     <= UA_RST;
			mode_r   <= pcv_pump_mode_t'(CFG_RST[`PCV_MODE_HI:`PCV_MODE_LO]);
			drive_r  <= 4'h8;
			misuse_r <= 1'b0;
		end
		else
		begin
			sense_r  <= sense_nxt;
			cur_r    <= cur_nxt;
			ua_r     <= ua_nxt;
			mode_r   <= mode_nxt;
			drive_r  <= drive_nxt;
			misuse_r <= misuse_nxt;
		end
	end

	//==============================================================
	// Pump control outputs
	assign detector_sense_select = sense_r;
	assign pump_current_select   = cur_r;
	assign pump_current_ua       = ua_r;
	assign pump_operating_mode   = mode_r;
	assign pump_source_en        = drive_r[0];
	assign pump_sink_en          = drive_r[1];
	assign pump_hiz              = drive_r[2];
	assign pump_normal           = drive_r[3];
	assign sense_misuse          = misuse_r;

endmodule : pcv_pump_cfg_regs

// ### pcv_pump_cfg_regs_properties.sv
// Concurrent checks for the pump configuration and version tag slice
`timescale 1ns/100ps
module pcv_pump_cfg_regs_properties
	import pcv_pkg::*;
(
	input wire logic           clk_sys,                     // Clock
	input wire logic           rst,                         // Reset
	input wire logic [11:0]    reg_addr,                    // Address
	input wire pcv_byte_t      reg_wdata,                   // Write data
	input wire logic           reg_wr,                      // Write strobe
	input wire logic           reg_rd,                      // Read strobe
	input wire pcv_byte_t      reg_rdata,                   // Read data
	input wire logic           reg_rvalid,                  // Read valid
	input wire logic [15:0]    stored_settings_version_tag, // Tag
	input wire logic           detector_sense_select,       // Sense
	input wire logic [2:0]     pump_current_select,         // Current code
	input wire logic [12:0]    pump_current_ua,             // Current
	input wire pcv_pump_mode_t pump_operating_mode,         // Mode
	input wire logic           pump_source_en,              // Forced up
	input wire logic           pump_sink_en,                // Forced down
	input wire logic           pump_hiz,                    // Output off
	input wire logic           pump_normal                  // Normal
);
	//==============================================================
	// Clocking and write sequences
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence cfg_wr_s;
		reg_wr && reg_addr == 12'h010;
	endsequence
	sequence other_wr_s;
		reg_wr && reg_addr != 12'h010;
	endsequence

	//==============================================================
	// Assertions
	read_valid_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read strobe gave no valid pulse");
	tag_low_a: assert property (
		reg_wr && reg_addr == 12'h005 |=> stored_settings_version_tag[7:0] == $past(reg_wdata))
		else $error("low tag byte not written");
	tag_high_a: assert property (
		reg_wr && reg_addr == 12'h006 |=> stored_settings_version_tag[15:8] == $past(reg_wdata))
		else $error("high tag byte not written");
	pump_isolated_a: assert property (
		other_wr_s |=> $stable({detector_sense_select, pump_current_select, pump_operating_mode}))
		else $error("pump setting moved on another write");
	sense_write_a: assert property (cfg_wr_s |=> detector_sense_select == $past(reg_wdata[7]))
		else $error("sense bit not written");
	current_write_a: assert property (
		cfg_wr_s |=> pump_current_select == $past(reg_wdata[6:4])
		&& pump_current_ua == (13'($past(reg_wdata[6:4])) + 13'h1) * 13'h258)
		else $error("pump current wrong after write");
	mode_write_a: assert property (cfg_wr_s |=> pump_operating_mode == $past(reg_wdata[3:2]))
		else $error("pump mode not written");
	mode_decode_a: assert property (
		{pump_normal, pump_sink_en, pump_source_en, pump_hiz} == 4'h1 << pump_operating_mode)
		else $error("pump mode decode wrong");
	cfg_read_a: assert property (
		reg_rd && !reg_wr && reg_addr == 12'h010 |=> reg_rdata ==
		{detector_sense_select, pump_current_select, pump_operating_mode, 2'h0})
		else $error("config read differs from settings");
endmodule : pcv_pump_cfg_regs_properties

bind pcv_pump_cfg_regs pcv_pump_cfg_regs_properties pcv_pump_cfg_regs_properties_i (.*);

// ### tb_pcv_pump_cfg_regs.sv
// Self-checking bench for the pump configuration and version tag slice
`timescale 1ns/100ps
module tb_pcv_pump_cfg_regs;
	import pcv_pkg::*;
	logic           clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic           osc_internal = 1'b0;
	logic [11:0]    reg_addr = 12'h000;
	pcv_byte_t      reg_wdata = 8'h00, reg_rdata;
	logic           reg_rvalid, reg_hit, detector_sense_select, sense_misuse;
	logic           pump_source_en, pump_sink_en, pump_hiz, pump_normal;
	logic [15:0]    stored_settings_version_tag;
	logic [2:0]     pump_current_select;
	logic [12:0]    pump_current_ua;
	pcv_pump_mode_t pump_operating_mode;
	int             miscompares = 0, num_checks = 0, m_lo, m_hi, m_cfg, i;

	pcv_pump_cfg_regs pcv_pump_cfg_regs_i (.*);

	// Clock generator
	always #12.5 clk_sys = ~clk_sys;

	//==============================================================
	// Compare, model and bus tasks
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic int exp_rd(input logic [11:0] a);
		return a == 12'h005 ? m_lo : a == 12'h006 ? m_hi : a == 12'h010 ? m_cfg : 0;
	endfunction : exp_rd
	task automatic chk_out;
		chk("tag", 16'(m_hi * 256 + m_lo), stored_settings_version_tag);
		chk("sense", 16'(m_cfg[7]), 16'(detector_sense_select));
		chk("cur", 16'(m_cfg[6:4]), 16'(pump_current_select));
		chk("ua", (m_cfg[6:4] + 16'h1) * 16'h258, 16'(pump_current_ua));
		chk("mode", 16'(m_cfg[3:2]), 16'(pump_operating_mode));
		chk("dec", 16'h1 << m_cfg[3:2], {12'h0, pump_normal, pump_sink_en, pump_source_en, pump_hiz});
		chk("misuse", 16'(m_cfg[7] & osc_internal), 16'(sense_misuse));
	endtask : chk_out
	task automatic wr(input logic [11:0] a, input pcv_byte_t d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		// Chip oscillator only while the resulting sense is positive
		osc_internal <= ((a == 12'h010) ? d[7] : 1'(m_cfg[7])) ? 1'b0 : 1'($urandom);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		if (a == 12'h005) m_lo = d;
		if (a == 12'h006) m_hi = d;
		if (a == 12'h010) m_cfg = d & 8'hfc;
		#1 chk_out();
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", 16'h1, 16'(reg_rvalid));
		chk("rdata", 16'(exp_rd(a)), 16'(reg_rdata));
		chk("hit", 16'(a inside {12'h005, 12'h006, 12'h010}), 16'(reg_hit));
		chk_out();
	endtask : rd
	task automatic do_reset;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		m_lo = 8'h00;
		m_hi = 8'h00;
		m_cfg = 8'h7c;
		#1 chk_out();
	endtask : do_reset
	task automatic report_and_stop;
		$display("Checks made %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	//==============================================================
	// Main sequence
	initial
	begin
		i = $urandom(32'he4fa);
		do_reset();
		rd(12'h005);
		rd(12'h006);
		rd(12'h010);
		for (i = 0; i < 32; i++)
		begin
			wr(12'h010, {1'($urandom), i[2:0], i[4:3], 2'($urandom)});
			rd(12'h010);
		end
		for (i = 0; i < 4; i++)
		begin
			wr(12'h005, 8'($urandom));
			wr(12'h006, 8'($urandom));
			rd(12'h005);
			rd(12'h006);
		end
		// Deliberate misuse: negative sense, then the chip oscillator is selected
		wr(12'h010, 8'h8f);
		@(posedge clk_sys);
		osc_internal <= 1'b1;
		@(posedge clk_sys);
		#1 chk_out();
		wr(12'h007, 8'hff);
		rd(12'h007);
		do_reset();
		rd(12'h010);
		rd(12'h006);
		report_and_stop();
	end

	// Watchdog against a hang
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		miscompares++;
		report_and_stop();
	end
endmodule : tb_pcv_pump_cfg_regs
